//--- pkg/dsad_cfg.svh
// timing-free constants: address map, field positions and reset values
`ifndef DSAD_CFG_SVH
`define DSAD_CFG_SVH
`define DSAD_ADDR_W        16
`define DSAD_WINDOW_BIT    15
`define DSAD_RAM_BYTES     16384
`define DSAD_PCR_LAST      16'h07FF
`define DSAD_NEAR_LAST     16'h1FFF
`define DSAD_NEAR_W        13
`define DSAD_XY_BOUNDARY   16'h2000
`define DSAD_DPR_BYTES     2048
`define DSAD_WORD_STEP     16'h0002
`define DSAD_BYTE_STEP     16'h0001
`define DSAD_ZERO_WORD     16'h0000
`define DSAD_RST_DATA      16'h0000
`endif

//--- pkg/dsad_pkg.sv
// types shared by the data-space access logic
package dsad_pkg;
  typedef enum logic [1:0] {
    DSAD_REG_RAM,
    DSAD_REG_PCR,
    DSAD_REG_WINDOW,
    DSAD_REG_NONE
  } dsad_region_t;
  typedef enum logic [1:0] {
    DSAD_MODE_ABS16,
    DSAD_MODE_NEAR13,
    DSAD_MODE_POINTER
  } dsad_mode_t;
  typedef enum logic {
    DSAD_TRAP_IDLE,
    DSAD_TRAP_PENDING
  } dsad_trap_state_t;
endpackage

//--- verilog/dsad_dual_port_ram.sv
// dual-ported shared memory at the top of Y space, CPU and DMA ports
`timescale 1ns/100ps
`include "dsad_cfg.svh"
module dsad_dual_port_ram #(
  parameter int WORDS = `DSAD_DPR_BYTES / 2,
  parameter int AW    = $clog2(`DSAD_DPR_BYTES / 2)
) (
  input  wire logic          i_clock,
  input  wire logic [AW-1:0] i_cpu_word,
  input  wire logic [1:0]    i_cpu_we,
  input  wire logic [15:0]   i_cpu_wdata,
  output logic      [15:0]   o_cpu_rdata,
  input  wire logic [AW-1:0] i_dma_word,
  input  wire logic [1:0]    i_dma_we,
  input  wire logic [15:0]   i_dma_wdata,
  output logic      [15:0]   o_dma_rdata
);
  if (WORDS < 1 || (1 << AW) < WORDS) begin : g_size
    $error("dual port memory size does not fit its address width");
  end
  logic [7:0] mem_lo [WORDS];
  logic [7:0] mem_hi [WORDS];
  wire        same_word = (i_cpu_word == i_dma_word);
  // cpu lanes mask the dma lanes on a shared word
  wire  [1:0] dma_we_eff = same_word ? (i_dma_we & ~i_cpu_we) : i_dma_we;
  // both ports act in the same cycle, no stall
  always_ff @(posedge i_clock) begin
    if (dma_we_eff[0]) begin
      mem_lo[i_dma_word] <= i_dma_wdata[7:0];
    end
    if (dma_we_eff[1]) begin
      mem_hi[i_dma_word] <= i_dma_wdata[15:8];
    end
    if (i_cpu_we[0]) begin
      mem_lo[i_cpu_word] <= i_cpu_wdata[7:0];
    end
    if (i_cpu_we[1]) begin
      mem_hi[i_cpu_word] <= i_cpu_wdata[15:8];
    end
    o_cpu_rdata <= {mem_hi[i_cpu_word], mem_lo[i_cpu_word]};
    o_dma_rdata <= {mem_hi[i_dma_word], mem_lo[i_dma_word]};
  end
endmodule

//--- verilog/dsad_data_space.sv
// data-space address decode, byte lanes, X/Y read paths and shared memory
`timescale 1ns/100ps
`include "dsad_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - addresses are 16-bit byte addresses, 64 Kbytes
// - top bit clear is memory, set is window
// - up to 16 Kbytes; outside reads zero
// - low byte even address, high byte odd
// - post-increment adds one per byte, two per word
// - byte read picks byte onto low lane
// - byte write strobes only the matching half
// - odd word access raises address error trap
// - misaligned write suppressed; trap follows instruction
// - byte load changes only register low byte
// - lowest 2 Kbytes go to peripheral registers
// - unused peripheral addresses read zero
// - 13-bit direct field reaches lowest 8 Kbytes
// - 16-bit direct or pointer reaches everything
// - separate X and Y read paths, same cycle unless Y reads shared memory while X uses it
// - X has read and write buses; X reads combined
// - bit-reverse only on X writes; modulo excluded
// - writes use combined space; fixed X/Y boundary
// - shared memory at Y top, concurrent DMA
// - CPU wins same-location write, never stalls
module dsad_data_space #(
  parameter int RAM_BYTES = `DSAD_RAM_BYTES,
  parameter int DPR_BYTES = `DSAD_DPR_BYTES
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // X read request
  input  wire logic        i_xr_valid,
  input  wire logic [1:0]  i_xr_mode,
  input  wire logic [15:0] i_xr_pointer,
  input  wire logic [15:0] i_xr_direct,
  input  wire logic        i_xr_byte,
  input  wire logic        i_xr_post_inc,
  input  wire logic [15:0] i_xr_reg_old,
  output logic      [15:0] o_xr_data,
  output logic      [15:0] o_xr_load,
  output logic      [15:0] o_xr_next_pointer,
  // Y read request
  input  wire logic        i_yr_valid,
  input  wire logic [15:0] i_yr_pointer,
  input  wire logic        i_yr_post_inc,
  output logic      [15:0] o_yr_data,
  output logic      [15:0] o_yr_next_pointer,
  // X write request
  input  wire logic        i_xw_valid,
  input  wire logic [1:0]  i_xw_mode,
  input  wire logic [15:0] i_xw_pointer,
  input  wire logic [15:0] i_xw_direct,
  input  wire logic        i_xw_byte,
  input  wire logic        i_xw_post_inc,
  input  wire logic [15:0] i_xw_data,
  output logic      [15:0] o_xw_next_pointer,
  // peripheral register area
  output logic             o_pcr_rd,
  output logic             o_pcr_wr,
  output logic      [15:0] o_pcr_addr,
  output logic      [1:0]  o_pcr_we,
  output logic      [15:0] o_pcr_wdata,
  input  wire logic [15:0] i_pcr_rdata,
  input  wire logic        i_pcr_hit,
  // program window
  output logic             o_window_rd,
  output logic      [14:0] o_window_addr,
  input  wire logic [15:0] i_window_rdata,
  // instruction boundary and trap
  input  wire logic        i_instr_end,
  output logic             o_address_trap,
  // dma port of the shared memory
  input  wire logic        i_dma_valid,
  input  wire logic        i_dma_write,
  input  wire logic [15:0] i_dma_addr,
  input  wire logic [1:0]  i_dma_we,
  input  wire logic [15:0] i_dma_wdata,
  output logic      [15:0] o_dma_rdata,
  output logic             o_dma_ready
);
  localparam int DPR_AW = $clog2(DPR_BYTES / 2);
  localparam int RAM_AW = $clog2(RAM_BYTES / 2);
  localparam logic [15:0] DPR_BASE = 16'(RAM_BYTES - DPR_BYTES);
  // the decode needs power-of-two sizes with the shared part inside memory
  if (RAM_BYTES > `DSAD_RAM_BYTES || DPR_BYTES > `DSAD_DPR_BYTES || DPR_BYTES < 2 ||
      DPR_BYTES > RAM_BYTES || RAM_BYTES <= `DSAD_PCR_LAST + 1 ||
      (RAM_BYTES & (RAM_BYTES - 1)) != 0 || (DPR_BYTES & (DPR_BYTES - 1)) != 0) begin : g_size
    $error("memory sizes outside what the decoder serves");
  end
  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic dsad_pkg::dsad_region_t region_of(input logic [15:0] a);
    if (a[`DSAD_WINDOW_BIT]) begin
      region_of = dsad_pkg::DSAD_REG_WINDOW;
    end else if (a <= `DSAD_PCR_LAST) begin
      region_of = dsad_pkg::DSAD_REG_PCR;
    end else if (a < 16'(RAM_BYTES)) begin
      region_of = dsad_pkg::DSAD_REG_RAM;
    end else begin
      region_of = dsad_pkg::DSAD_REG_NONE;
    end
  endfunction
  // near mode keeps only the low 13 bits, so it cannot leave the lowest 8 Kbytes
  function automatic logic [15:0] ea_of(input logic [1:0] mode, input logic [15:0] ptr,
                                        input logic [15:0] dir);
    unique case (dsad_pkg::dsad_mode_t'(mode))
      dsad_pkg::DSAD_MODE_NEAR13:  ea_of = {3'h0, dir[`DSAD_NEAR_W-1:0]};
      dsad_pkg::DSAD_MODE_ABS16:   ea_of = dir;
      dsad_pkg::DSAD_MODE_POINTER: ea_of = ptr;
      default:                     ea_of = ptr;
    endcase
  endfunction
  function automatic logic [15:0] step_of(input logic [15:0] p, input logic byt,
                                          input logic inc);
    step_of = !inc ? p : (byt ? p + `DSAD_BYTE_STEP : p + `DSAD_WORD_STEP);
  endfunction
  // shared memory is the top part of implemented memory, inside Y space
  function automatic logic in_dpr(input logic [15:0] a);
    in_dpr = (a >= DPR_BASE) && (a < 16'(RAM_BYTES));
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // reset release
  // release is synchronised so every flop leaves reset on the same edge
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  wire rst_b = rst_sync;
  //////////////////////////////////////////////////////////////////////////////
  // address decode: all 16 bits are byte addresses
  wire [15:0] xr_ea = ea_of(i_xr_mode, i_xr_pointer, i_xr_direct);
  wire [15:0] xw_ea = ea_of(i_xw_mode, i_xw_pointer, i_xw_direct);
  wire [15:0] yr_ea = i_yr_pointer;
  wire dsad_pkg::dsad_region_t xr_reg = region_of(xr_ea);
  wire dsad_pkg::dsad_region_t xw_reg = region_of(xw_ea);
  wire dsad_pkg::dsad_region_t yr_reg = region_of(yr_ea);
  // word access to odd address is misaligned; Y reads are always words
  wire xr_mis = i_xr_valid && !i_xr_byte && xr_ea[0];
  wire xw_mis = i_xw_valid && !i_xw_byte && xw_ea[0];
  wire yr_mis = i_yr_valid && yr_ea[0];
  // even address is low byte, odd is high byte
  wire [1:0] xw_lanes = i_xw_byte ? (xw_ea[0] ? 2'h2 : 2'h1) : 2'h3;
  // a byte write puts its byte on both lanes; the strobes pick the half
  wire [15:0] xw_lane_data = i_xw_byte ? {2{i_xw_data[7:0]}} : i_xw_data;
  // writes decode over the combined space, suppressed on misalignment
  wire xw_go = i_xw_valid && !xw_mis;
  wire xw_ram = xw_go && xw_reg == dsad_pkg::DSAD_REG_RAM;
  wire xw_dpr = xw_ram && in_dpr(xw_ea);
  wire xw_main = xw_ram && !in_dpr(xw_ea);
  // an idle read path must not take the shared port from a live request
  wire xr_dpr = i_xr_valid && in_dpr(xr_ea);
  wire yr_dpr = i_yr_valid && in_dpr(yr_ea);
  //////////////////////////////////////////////////////////////////////////////
  // main memory: shared word decode with two byte halves
  logic [7:0] ram_lo [RAM_BYTES / 2];
  logic [7:0] ram_hi [RAM_BYTES / 2];
  wire [RAM_AW-1:0] xw_word = xw_ea[RAM_AW:1];
  wire [RAM_AW-1:0] xr_word = xr_ea[RAM_AW:1];
  wire [RAM_AW-1:0] yr_word = yr_ea[RAM_AW:1];
  logic [15:0] xr_ram_q;
  logic [15:0] yr_ram_q;
  always_ff @(posedge i_clock) begin
    if (xw_main && xw_lanes[0]) begin
      ram_lo[xw_word] <= xw_lane_data[7:0];
    end
    if (xw_main && xw_lanes[1]) begin
      ram_hi[xw_word] <= xw_lane_data[15:8];
    end
    // X and Y read ports in the same cycle
    xr_ram_q <= {ram_hi[xr_word], ram_lo[xr_word]};
    yr_ram_q <= {ram_hi[yr_word], ram_lo[yr_word]};
  end
  //////////////////////////////////////////////////////////////////////////////
  // shared memory: CPU port carries X write, else X read, else Y read
  wire [15:0] dpr_cpu_ea = xw_dpr ? xw_ea : (xr_dpr ? xr_ea : yr_ea);
  // shared memory is indexed from its own base, one word per two bytes
  wire [DPR_AW-1:0] dpr_cpu_word = DPR_AW'((dpr_cpu_ea - DPR_BASE) >> 1);
  wire [DPR_AW-1:0] dpr_dma_word = DPR_AW'((i_dma_addr - DPR_BASE) >> 1);
  wire [1:0] dpr_cpu_we = xw_dpr ? xw_lanes : 2'h0;
  wire [1:0] dpr_dma_we = (i_dma_valid && i_dma_write && in_dpr(i_dma_addr)) ? i_dma_we : 2'h0;
  logic [15:0] dpr_cpu_q;
  dsad_dual_port_ram #(
    .WORDS (DPR_BYTES / 2),
    .AW    (DPR_AW)
  ) u_dpr (
    .i_clock     (i_clock),
    .i_cpu_word  (dpr_cpu_word),
    .i_cpu_we    (dpr_cpu_we),
    .i_cpu_wdata (xw_lane_data),
    .o_cpu_rdata (dpr_cpu_q),
    .i_dma_word  (dpr_dma_word),
    .i_dma_we    (dpr_dma_we),
    .i_dma_wdata (i_dma_wdata),
    .o_dma_rdata (o_dma_rdata)
  );
  // dma never waits and the CPU never waits for it
  assign o_dma_ready = 1'b1;
  //////////////////////////////////////////////////////////////////////////////
  // peripheral area and program window, combinational requests
  // a misaligned read strobes no register, so no read side effect fires
  assign o_pcr_rd = i_xr_valid && !xr_mis && xr_reg == dsad_pkg::DSAD_REG_PCR;
  assign o_pcr_wr = xw_go && xw_reg == dsad_pkg::DSAD_REG_PCR;
  assign o_pcr_addr = o_pcr_wr ? xw_ea : xr_ea;
  assign o_pcr_we = o_pcr_wr ? xw_lanes : 2'h0;
  assign o_pcr_wdata = xw_lane_data;
  assign o_window_rd = i_xr_valid && xr_reg == dsad_pkg::DSAD_REG_WINDOW;
  assign o_window_addr = xr_ea[14:0];
  //////////////////////////////////////////////////////////////////////////////
  // read return, one cycle after request
  logic                  xr_byte_q;
  logic                  xr_hi_q;
  logic                  xr_dpr_q;
  logic                  xr_lost_q;
  logic                  yr_dpr_q;
  logic [15:0]           xr_reg_old_q;
  logic [15:0]           pcr_q;
  logic [15:0]           win_q;
  dsad_pkg::dsad_region_t xr_reg_q;
  dsad_pkg::dsad_region_t yr_reg_q;
  always_ff @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      xr_byte_q    <= 1'b0;
      xr_hi_q      <= 1'b0;
      xr_dpr_q     <= 1'b0;
      xr_lost_q    <= 1'b0;
      yr_dpr_q     <= 1'b0;
      xr_reg_old_q <= `DSAD_RST_DATA;
      pcr_q        <= `DSAD_RST_DATA;
      win_q        <= `DSAD_RST_DATA;
      xr_reg_q     <= dsad_pkg::DSAD_REG_NONE;
      yr_reg_q     <= dsad_pkg::DSAD_REG_NONE;
    end else begin
      xr_byte_q    <= i_xr_byte;
      xr_hi_q      <= xr_ea[0];
      xr_dpr_q     <= xr_dpr && !xw_dpr;
      xr_lost_q    <= xr_dpr && xw_dpr;
      yr_dpr_q     <= yr_dpr && !xw_dpr && !xr_dpr;
      xr_reg_old_q <= i_xr_reg_old;
      pcr_q        <= i_pcr_hit ? i_pcr_rdata : `DSAD_ZERO_WORD;
      win_q        <= i_window_rdata;
      xr_reg_q     <= i_xr_valid ? xr_reg : dsad_pkg::DSAD_REG_NONE;
      yr_reg_q     <= i_yr_valid ? yr_reg : dsad_pkg::DSAD_REG_NONE;
    end
  end
  // an X read that loses the shared port to a same-cycle X write reads zero
  wire [15:0] xr_word_data =
    (xr_reg_q == dsad_pkg::DSAD_REG_RAM && xr_lost_q) ? `DSAD_ZERO_WORD :
    (xr_reg_q == dsad_pkg::DSAD_REG_RAM) ? (xr_dpr_q ? dpr_cpu_q : xr_ram_q) :
    (xr_reg_q == dsad_pkg::DSAD_REG_PCR) ? pcr_q :
    (xr_reg_q == dsad_pkg::DSAD_REG_WINDOW) ? win_q : `DSAD_ZERO_WORD;
  wire [15:0] yr_word_data =
    (yr_reg_q != dsad_pkg::DSAD_REG_RAM) ? `DSAD_ZERO_WORD :
    (yr_dpr_q ? dpr_cpu_q : yr_ram_q);
  // selected byte lands on the low lane
  wire [7:0] xr_sel_byte = xr_hi_q ? xr_word_data[15:8] : xr_word_data[7:0];
  assign o_xr_data = xr_byte_q ? {8'h00, xr_sel_byte} : xr_word_data;
  assign o_xr_load = xr_byte_q ? {xr_reg_old_q[15:8], xr_sel_byte} : xr_word_data;
  assign o_yr_data = yr_word_data;
  //////////////////////////////////////////////////////////////////////////////
  // pointer update; bit-reverse and modulo are done upstream
  assign o_xr_next_pointer = step_of(i_xr_pointer, i_xr_byte, i_xr_post_inc);
  assign o_yr_next_pointer = step_of(i_yr_pointer, 1'b0, i_yr_post_inc);
  assign o_xw_next_pointer = step_of(i_xw_pointer, i_xw_byte, i_xw_post_inc);
  //////////////////////////////////////////////////////////////////////////////
  // address error trap, held until instruction end
  dsad_pkg::dsad_trap_state_t trap_state;
  dsad_pkg::dsad_trap_state_t next_trap_state;
  wire any_mis = xr_mis || xw_mis || yr_mis;
  // a misaligned access in the last cycle of an instruction traps at once
  always_comb begin
    next_trap_state = trap_state;
    unique case (trap_state)
      dsad_pkg::DSAD_TRAP_IDLE: begin
        if (any_mis) begin
          next_trap_state = i_instr_end ? dsad_pkg::DSAD_TRAP_IDLE
                                        : dsad_pkg::DSAD_TRAP_PENDING;
        end
      end
      dsad_pkg::DSAD_TRAP_PENDING: begin
        if (i_instr_end) begin
          next_trap_state = dsad_pkg::DSAD_TRAP_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      trap_state     <= dsad_pkg::DSAD_TRAP_IDLE;
      o_address_trap <= 1'b0;
    end else begin
      trap_state     <= next_trap_state;
      // trap taken after the instruction completes
      o_address_trap <= i_instr_end &&
                        (any_mis || trap_state == dsad_pkg::DSAD_TRAP_PENDING);
    end
  end
endmodule

//--- verification/dsad_periph_model.sv
// responder for the peripheral register area and the program window
`timescale 1ns/100ps
module dsad_periph_model (
  input  wire logic        i_clock,
  input  wire logic        i_pcr_rd,
  input  wire logic [15:0] i_pcr_addr,
  input  wire logic        i_window_rd,
  output logic      [15:0] o_pcr_rdata,
  output logic             o_pcr_hit,
  output logic      [15:0] o_window_rdata
);
  logic [15:0] junk = 16'h0000;
  // unselected data lines churn so that a stale value never passes
  always_ff @(posedge i_clock) junk <= junk + 16'h3C5B;
  // only the lowest 256 bytes hold registers, the rest are unused
  assign o_pcr_hit      = i_pcr_rd && (i_pcr_addr < 16'h0100);
  assign o_pcr_rdata    = i_pcr_rd ? (i_pcr_addr ^ 16'h5A00) : junk;
  assign o_window_rdata = i_window_rd ? 16'hA5C3 : ~junk;
endmodule

//--- verification/dsad_data_space_chk.sv
// port-level assertions for the data-space access logic
`timescale 1ns/100ps
module dsad_data_space_chk #(
  parameter int RAM_BYTES = 16384
) (
  input wire logic        i_clock,
  input wire logic        i_rst_b,
  input wire logic        i_xr_valid,
  input wire logic [1:0]  i_xr_mode,
  input wire logic [15:0] i_xr_pointer,
  input wire logic [15:0] i_xr_direct,
  input wire logic        i_xr_byte,
  input wire logic        i_xr_post_inc,
  input wire logic [15:0] o_xr_data,
  input wire logic [15:0] o_xr_load,
  input wire logic [15:0] o_xr_next_pointer,
  input wire logic        i_yr_valid,
  input wire logic [15:0] i_yr_pointer,
  input wire logic        i_yr_post_inc,
  input wire logic [15:0] o_yr_next_pointer,
  input wire logic        i_xw_valid,
  input wire logic [1:0]  i_xw_mode,
  input wire logic [15:0] i_xw_direct,
  input wire logic        i_xw_byte,
  input wire logic        o_pcr_rd,
  input wire logic        o_pcr_wr,
  input wire logic [15:0] o_pcr_addr,
  input wire logic [1:0]  o_pcr_we,
  input wire logic        i_pcr_hit,
  input wire logic        o_window_rd,
  input wire logic        i_instr_end,
  input wire logic        o_address_trap,
  input wire logic        o_dma_ready
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  wire  xr_abs = i_xr_valid && (i_xr_mode == 2'h0) && !i_yr_valid;
  wire  xw_abs = i_xw_valid && (i_xw_mode == 2'h0);
  logic byte_q;
  always_ff @(posedge i_clock or negedge i_rst_b)
    if (!i_rst_b) byte_q <= 1'b0;
    else byte_q <= i_xr_valid && i_xr_byte;
  ////////////////////////////////////////////////////////////////////////////
  sequence s_odd_word_rd;
    xr_abs && !i_xr_byte && i_xr_direct[0] && i_instr_end;
  endsequence
  sequence s_trap_soon;
    ##[1:2] o_address_trap;
  endsequence
  a_step_byte: assert property (
    i_xr_mode == 2'h2 && i_xr_byte && i_xr_post_inc |->
    o_xr_next_pointer == i_xr_pointer + 16'h0001) else $error("byte step wrong");
  a_step_word: assert property (
    i_xr_mode == 2'h2 && !i_xr_byte && i_xr_post_inc |->
    o_xr_next_pointer == i_xr_pointer + 16'h0002) else $error("word step wrong");
  a_y_step: assert property (
    i_yr_post_inc |-> o_yr_next_pointer == i_yr_pointer + 16'h0002)
    else $error("y step wrong");
  a_window_map: assert property (
    xr_abs && i_xr_direct[15] |-> o_window_rd) else $error("window not selected");
  a_ram_limit: assert property (
    xr_abs && !i_xr_direct[15] && int'(i_xr_direct) >= RAM_BYTES |=>
    o_xr_data == 16'h0000) else $error("outside read not zero");
  a_pcr_map: assert property (
    o_pcr_rd || o_pcr_wr |-> o_pcr_addr <= 16'h07FF) else $error("pcr strobe out of area");
  a_pcr_unused: assert property (
    xr_abs && o_pcr_rd && !i_pcr_hit |=> o_xr_data == 16'h0000)
    else $error("unused pcr not zero");
  a_byte_strobe: assert property (
    xw_abs && i_xw_byte && o_pcr_wr |-> o_pcr_we == (i_xw_direct[0] ? 2'h2 : 2'h1))
    else $error("byte lane wrong");
  a_no_mis_wr: assert property (
    xw_abs && !i_xw_byte && i_xw_direct[0] |-> !o_pcr_wr) else $error("misaligned write");
  a_odd_trap: assert property (
    s_odd_word_rd |-> s_trap_soon) else $error("no trap on odd word");
  a_trap_cause: assert property (
    o_address_trap |-> $past(i_instr_end) || $past(i_instr_end, 2))
    else $error("trap not after instruction end");
  a_rd_byte_low: assert property (
    byte_q |-> o_xr_data[15:8] == 8'h00 && o_xr_load[7:0] == o_xr_data[7:0])
    else $error("byte lane of read wrong");
  a_dma_ready: assert property (
    o_dma_ready) else $error("dma stalled");
endmodule

//--- verification/tb_data_space_address_decode.sv
// self-checking bench for the data-space access logic
`timescale 1ns/100ps
module tb_data_space_address_decode;
  logic        i_clock = 1'b0, i_rst_b = 1'b0, i_xr_valid = 1'b0, i_xr_byte = 1'b0;
  logic        i_xr_post_inc = 1'b0, i_yr_valid = 1'b0, i_yr_post_inc = 1'b0;
  logic        i_xw_valid = 1'b0, i_xw_byte = 1'b0, i_xw_post_inc = 1'b0;
  logic        i_instr_end = 1'b0, i_dma_valid = 1'b0, i_dma_write = 1'b0;
  logic [1:0]  i_xr_mode = 2'h0, i_xw_mode = 2'h0, i_dma_we = 2'h0;
  logic [15:0] i_xr_pointer = 16'h0000, i_xr_direct = 16'h0000, i_xr_reg_old = 16'h0000;
  logic [15:0] i_yr_pointer = 16'h0000, i_xw_pointer = 16'h0000, i_xw_direct = 16'h0000;
  logic [15:0] i_xw_data = 16'h0000, i_dma_addr = 16'h0000, i_dma_wdata = 16'h0000;
  logic [15:0] o_xr_data, o_xr_load, o_xr_next_pointer, o_yr_data, o_yr_next_pointer;
  logic [15:0] o_xw_next_pointer, o_pcr_addr, o_pcr_wdata, i_pcr_rdata, o_dma_rdata;
  logic [15:0] i_window_rdata;
  logic        o_pcr_rd, o_pcr_wr, i_pcr_hit, o_window_rd, o_address_trap, o_dma_ready;
  logic [1:0]  o_pcr_we;
  logic [14:0] o_window_addr;
  int          miscompares = 0, n_tests = 0;
  always #2.5 i_clock = ~i_clock;
  dsad_data_space i_dut (.i_clock, .i_rst_b, .i_xr_valid, .i_xr_mode, .i_xr_pointer,
    .i_xr_direct, .i_xr_byte, .i_xr_post_inc, .i_xr_reg_old, .o_xr_data, .o_xr_load,
    .o_xr_next_pointer, .i_yr_valid, .i_yr_pointer, .i_yr_post_inc, .o_yr_data,
    .o_yr_next_pointer, .i_xw_valid, .i_xw_mode, .i_xw_pointer, .i_xw_direct, .i_xw_byte,
    .i_xw_post_inc, .i_xw_data, .o_xw_next_pointer, .o_pcr_rd, .o_pcr_wr, .o_pcr_addr,
    .o_pcr_we, .o_pcr_wdata, .i_pcr_rdata, .i_pcr_hit, .o_window_rd, .o_window_addr,
    .i_window_rdata, .i_instr_end, .o_address_trap, .i_dma_valid, .i_dma_write,
    .i_dma_addr, .i_dma_we, .i_dma_wdata, .o_dma_rdata, .o_dma_ready);
  dsad_periph_model i_model (.i_clock, .i_pcr_rd(o_pcr_rd), .i_pcr_addr(o_pcr_addr),
    .i_window_rd(o_window_rd), .o_pcr_rdata(i_pcr_rdata), .o_pcr_hit(i_pcr_hit),
    .o_window_rdata(i_window_rdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic b);
    @(posedge i_clock);
    i_xw_valid <= 1'b1;
    i_xw_direct <= a;
    i_xw_data <= d;
    i_xw_byte <= b;
    @(posedge i_clock);
    i_xw_valid <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] m, input logic [15:0] a, input logic b,
                    output logic [15:0] d, output logic [15:0] l, output logic [15:0] np);
    @(posedge i_clock);
    i_xr_valid <= 1'b1;
    i_xr_mode <= m;
    i_xr_direct <= a;
    i_xr_pointer <= a;
    i_xr_byte <= b;
    i_xr_post_inc <= (m == 2'h2);
    #1 np = o_xr_next_pointer;
    @(posedge i_clock);
    i_xr_valid <= 1'b0;
    i_xr_post_inc <= 1'b0;
    #1 d = o_xr_data;
    l = o_xr_load;
  endtask
  task automatic wait_trap();
    n_tests++;
    for (int k = 0; k < 4; k++) begin
      #1;
      if (o_address_trap === 1'b1) return;
      @(posedge i_clock);
    end
    miscompares++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    conclude();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_lanes();
    logic [15:0] d, l, np;
    wr(16'h0800, 16'h1234, 1'b0);
    rd(2'h0, 16'h0800, 1'b0, d, l, np);
    chk(d, 16'h1234);
    rd(2'h0, 16'h0801, 1'b1, d, l, np);
    chk(d, 16'h0012);
    wr(16'h0801, 16'h00AB, 1'b1);
    i_xr_reg_old <= 16'hCDEF;
    rd(2'h0, 16'h0800, 1'b1, d, l, np);
    chk(l, 16'hCD34);
    rd(2'h0, 16'h0800, 1'b0, d, l, np);
    chk(d, 16'hAB34);
  endtask
  task automatic t_map();
    logic [15:0] d, l, np;
    rd(2'h0, 16'h4000, 1'b0, d, l, np);
    chk(d, 16'h0000);
    rd(2'h0, 16'h4001, 1'b1, d, l, np);
    chk(d, 16'h0000);
    rd(2'h0, 16'h8002, 1'b0, d, l, np);
    chk(d, 16'hA5C3);
    chk({1'b0, o_window_addr}, 16'h0002);
    rd(2'h0, 16'h0010, 1'b0, d, l, np);
    chk(d, 16'h5A10);
    rd(2'h0, 16'h0700, 1'b0, d, l, np);
    chk(d, 16'h0000);
    wr(16'h0021, 16'h00EE, 1'b1);
  endtask
  task automatic t_modes();
    logic [15:0] d, l, np;
    wr(16'h0810, 16'h4321, 1'b0);
    rd(2'h1, 16'hE810, 1'b0, d, l, np);
    chk(d, 16'h4321);
    rd(2'h2, 16'h0810, 1'b0, d, l, np);
    chk(np, 16'h0812);
    chk(d, 16'h4321);
    rd(2'h2, 16'h0811, 1'b1, d, l, np);
    chk(np, 16'h0812);
    chk(d, 16'h0043);
  endtask
  task automatic t_xy();
    logic [15:0] d, l, np;
    wr(16'h0900, 16'h1111, 1'b0);
    wr(16'h3000, 16'h2222, 1'b0);
    i_yr_valid <= 1'b1;
    i_yr_pointer <= 16'h3000;
    i_yr_post_inc <= 1'b1;
    rd(2'h0, 16'h0900, 1'b0, d, l, np);
    chk(d, 16'h1111);
    chk(o_yr_data, 16'h2222);
    chk(o_yr_next_pointer, 16'h3002);
    i_yr_valid <= 1'b0;
    i_yr_post_inc <= 1'b0;
  endtask
  task automatic t_misalign();
    logic [15:0] d, l, np;
    wr(16'h0A00, 16'h7777, 1'b0);
    i_instr_end <= 1'b1;
    wr(16'h0A01, 16'h9999, 1'b0);
    i_instr_end <= 1'b0;
    wait_trap();
    rd(2'h0, 16'h0A00, 1'b0, d, l, np);
    chk(d, 16'h7777);
    i_instr_end <= 1'b1;
    rd(2'h0, 16'h0A03, 1'b0, d, l, np);
    i_instr_end <= 1'b0;
    wait_trap();
  endtask
  task automatic collide(input logic [15:0] a, input logic [15:0] cd, input logic cb,
                         input logic [15:0] da, input logic [15:0] dd);
    @(posedge i_clock);
    i_xw_valid <= 1'b1;
    i_xw_direct <= a;
    i_xw_data <= cd;
    i_xw_byte <= cb;
    i_dma_valid <= 1'b1;
    i_dma_write <= 1'b1;
    i_dma_addr <= da;
    i_dma_we <= 2'h3;
    i_dma_wdata <= dd;
    @(posedge i_clock);
    i_xw_valid <= 1'b0;
    i_dma_write <= 1'b0;
  endtask
  task automatic t_dma();
    logic [15:0] d, l, np;
    collide(16'h3810, 16'h1234, 1'b0, 16'h3820, 16'h5555);
    rd(2'h0, 16'h3810, 1'b0, d, l, np);
    chk(d, 16'h1234);
    rd(2'h0, 16'h3820, 1'b0, d, l, np);
    chk(d, 16'h5555);
    collide(16'h3810, 16'h9876, 1'b0, 16'h3810, 16'hFFFF);
    rd(2'h0, 16'h3810, 1'b0, d, l, np);
    chk(d, 16'h9876);
    collide(16'h3810, 16'h0056, 1'b1, 16'h3810, 16'hAAAA);
    rd(2'h0, 16'h3810, 1'b0, d, l, np);
    chk(d, 16'hAA56);
    chk(o_dma_rdata, 16'hAA56);
    i_dma_valid <= 1'b0;
  endtask
  task automatic t_pcr_write();
    @(posedge i_clock);
    i_xw_valid <= 1'b1;
    i_xw_direct <= 16'h0021;
    i_xw_pointer <= 16'h0021;
    i_xw_data <= 16'h00EE;
    i_xw_byte <= 1'b1;
    i_xw_post_inc <= 1'b1;
    #1 chk(o_pcr_addr, 16'h0021);
    chk({14'h0000, o_pcr_we}, 16'h0002);
    chk(o_pcr_wdata, 16'hEEEE);
    chk(o_xw_next_pointer, 16'h0022);
    @(posedge i_clock);
    i_xw_byte <= 1'b0;
    i_xw_direct <= 16'h0023;
    i_xw_pointer <= 16'h0023;
    #1 chk({15'h0000, o_pcr_wr}, 16'h0000);
    chk(o_xw_next_pointer, 16'h0025);
    @(posedge i_clock);
    i_xw_valid <= 1'b0;
    i_xw_post_inc <= 1'b0;
    #1 chk({15'h0000, o_address_trap}, 16'h0000);
    @(posedge i_clock);
    i_instr_end <= 1'b1;
    @(posedge i_clock);
    i_instr_end <= 1'b0;
    wait_trap();
  endtask
  initial begin
    repeat (12) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clock);
    t_lanes();
    t_map();
    t_pcr_write();
    t_modes();
    t_xy();
    t_misalign();
    t_dma();
    conclude();
  end
endmodule
bind dsad_data_space dsad_data_space_chk #(.RAM_BYTES(RAM_BYTES)) i_chk (.i_clock, .i_rst_b,
  .i_xr_valid, .i_xr_mode, .i_xr_pointer, .i_xr_direct, .i_xr_byte, .i_xr_post_inc,
  .o_xr_data, .o_xr_load, .o_xr_next_pointer, .i_yr_valid, .i_yr_pointer, .i_yr_post_inc,
  .o_yr_next_pointer, .i_xw_valid, .i_xw_mode, .i_xw_direct, .i_xw_byte, .o_pcr_rd,
  .o_pcr_wr, .o_pcr_addr, .o_pcr_we, .i_pcr_hit, .o_window_rd, .i_instr_end,
  .o_address_trap, .o_dma_ready);
